// file: logic/dsp_multiply_accumulate.sv
// multiply and add datapath block with input, pipeline and output registers
// Function
// - every multiplier's a and b input registers optional, each on one of four sets
// - shift configuration loads registers from the previous multiplier, chained out
// - parallel load at every size; no input chaining for the largest multiplier
// - eight 9x9, four 18x18 or one 36x36 multiplier
// - sign lines mark operands signed when high; product signed if either is
// - sign lines apply block-wide and may be registered once for the multipliers
// - products are full precision for any sign setting
// - optional product register pipelines adders, or the large multiplier itself
// - output stage is product, accumulator, two-adder or four-adder; the large multiplier uses the product path
// - output register usable always, forced when accumulating; adders fed by multipliers
// - two add/subtract lines, high adds; per adder, or per half in small mode
// - add/subtract lines pass zero, one or two register stages
// - adder sign lines are the same signals, up to two stages, same set
// - accumulator feeds back; load line replaces it with the product
// - registered overflow flag per accumulator, not sticky
// - summation adds first-level results: two sums small mode, one sum middle mode
// - output multiplexer picks products, adder results or sums by mode
// - output registers take clock enable and clear from one of four sets
// - one arithmetic mode for the whole block at a time
// - accumulator result is 52 bits wide
`timescale 1ns/1ps
`default_nettype none
module dsp_multiply_accumulate
   import dsp_pkg::*;
(
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   // four block-wide control sets
   input  wire logic [N_SET-1:0]       set_tick,
   input  wire logic [N_SET-1:0]       set_ena,
   input  wire logic [N_SET-1:0]       set_clr,
   // static configuration
   input  wire size_t                  cfg_size,
   input  wire mode_t                  cfg_mode,
   input  wire logic [N_SLICE-1:0]     cfg_in_reg_a,
   input  wire logic [N_SLICE-1:0]     cfg_in_reg_b,
   input  wire logic [2*N_SLICE-1:0]   cfg_in_set_a,
   input  wire logic [2*N_SLICE-1:0]   cfg_in_set_b,
   input  wire logic                   cfg_shift_a,
   input  wire logic                   cfg_shift_b,
   input  wire logic                   cfg_pipe_reg,
   input  wire logic [SET_W-1:0]       cfg_pipe_set,
   input  wire logic                   cfg_out_reg,
   input  wire logic [SET_W-1:0]       cfg_out_set,
   input  wire logic [SET_W-1:0]       cfg_ctrl_set,
   input  wire logic                   cfg_sign_mult_depth,
   input  wire logic [1:0]             cfg_sign_add_depth,
   input  wire logic [1:0]             cfg_addnsub_depth,
   input  wire logic [1:0]             cfg_sload_depth,
   // operands and dynamic controls
   input  wire logic [LANE_W-1:0]      data_a,
   input  wire logic [LANE_W-1:0]      data_b,
   input  wire logic [CASC_W-1:0]      cascade_in_a,
   input  wire logic [CASC_W-1:0]      cascade_in_b,
   input  wire logic                   sign_a,
   input  wire logic                   sign_b,
   input  wire logic [1:0]             addnsub,
   input  wire logic [1:0]             accum_sload,
   // results
   output logic      [VEC_W-1:0]       result,
   output logic      [1:0]             overflow,
   output logic      [CASC_W-1:0]      cascade_out_a,
   output logic      [CASC_W-1:0]      cascade_out_b
);
   typedef struct packed {
      logic [VEC_W-1:0] pipe;
      logic [VEC_W-1:0] out;
      logic [1:0]       ovf;
   } mac_state_t;

   mac_state_t r;
   mac_state_t next_r;

   logic [LANE_W-1:0]  a_vec, b_vec, a_reg, b_reg;
   logic [LANE_W-1:0]  a_chain, b_chain;
   logic               shift_a_eff, shift_b_eff;
   mode_t              eff_mode;
   logic               use_out;
   logic [1:0]         sm, sadd, as_q, sl_q;
   logic               ctrl_tick, ctrl_ena, ctrl_clr;
   logic               pipe_ld, pipe_clr, out_ld, out_clr, ps;
   logic [VEC_W-1:0]   prod_now, prod_use, out_now, out_q;
   logic signed [LANE_W-1:0] pe [N_SLICE];
   logic signed [LANE_W-1:0] s  [4];
   logic signed [LANE_W-1:0] u  [2];
   logic [ACC_W:0]     sum53 [2];
   logic [ACC_W-1:0]   acc_res [2];
   logic [1:0]         ovf_now;

   // the large multiplier has no input chain and only the plain output path
   assign shift_a_eff = cfg_shift_a && (cfg_size != SIZE_36);
   assign shift_b_eff = cfg_shift_b && (cfg_size != SIZE_36);
   assign eff_mode    = (cfg_size == SIZE_36) ? MODE_SIMPLE : cfg_mode;
   assign use_out     = cfg_out_reg || (eff_mode == MODE_ACCUM);

   // chain source is one slice back or two; a whole-vector shift keeps every index in range
   assign a_chain = (cfg_size == SIZE_18)
                  ? {a_reg[LANE_W-CASC_W-1:0], cascade_in_a}
                  : {a_reg[LANE_W-SLICE_W-1:0], cascade_in_a[SLICE_W-1:0]};
   assign b_chain = (cfg_size == SIZE_18)
                  ? {b_reg[LANE_W-CASC_W-1:0], cascade_in_b}
                  : {b_reg[LANE_W-SLICE_W-1:0], cascade_in_b[SLICE_W-1:0]};

   // operand registers, each with its own control set
   for (genvar g = 0; g < N_SLICE; g++) begin : g_slice
      dsp_operand_slice u_a (
         .sys_clk   (sys_clk),
         .rst_n     (rst_n),
         .tick      (set_tick[cfg_in_set_a[g*SET_W +: SET_W]]),
         .ena       (set_ena[cfg_in_set_a[g*SET_W +: SET_W]]),
         .clr       (set_clr[cfg_in_set_a[g*SET_W +: SET_W]]),
         .use_reg   (cfg_in_reg_a[g] || shift_a_eff),
         .shift_sel (shift_a_eff),
         .par_in    (data_a[g*SLICE_W +: SLICE_W]),
         .shift_in  (a_chain[g*SLICE_W +: SLICE_W]),
         .q         (a_vec[g*SLICE_W +: SLICE_W]),
         .reg_q     (a_reg[g*SLICE_W +: SLICE_W])
      );
      dsp_operand_slice u_b (
         .sys_clk   (sys_clk),
         .rst_n     (rst_n),
         .tick      (set_tick[cfg_in_set_b[g*SET_W +: SET_W]]),
         .ena       (set_ena[cfg_in_set_b[g*SET_W +: SET_W]]),
         .clr       (set_clr[cfg_in_set_b[g*SET_W +: SET_W]]),
         .use_reg   (cfg_in_reg_b[g] || shift_b_eff),
         .shift_sel (shift_b_eff),
         .par_in    (data_b[g*SLICE_W +: SLICE_W]),
         .shift_in  (b_chain[g*SLICE_W +: SLICE_W]),
         .q         (b_vec[g*SLICE_W +: SLICE_W]),
         .reg_q     (b_reg[g*SLICE_W +: SLICE_W])
      );
   end

   // chain leaves from the last multiplier; its width follows the size
   assign cascade_out_a = (cfg_size == SIZE_18)
                        ? a_reg[LANE_W-1 -: CASC_W]
                        : {{SLICE_W{1'b0}}, a_reg[LANE_W-1 -: SLICE_W]};
   assign cascade_out_b = (cfg_size == SIZE_18)
                        ? b_reg[LANE_W-1 -: CASC_W]
                        : {{SLICE_W{1'b0}}, b_reg[LANE_W-1 -: SLICE_W]};

   // all dynamic control lines share one set so they stay aligned
   assign ctrl_tick = set_tick[cfg_ctrl_set];
   assign ctrl_ena  = set_ena[cfg_ctrl_set];
   assign ctrl_clr  = set_clr[cfg_ctrl_set];

   dsp_ctrl_delay #(.W(2)) u_sign_mult (
      .sys_clk (sys_clk), .rst_n (rst_n), .tick (ctrl_tick), .ena (ctrl_ena), .clr (ctrl_clr),
      .depth   ({1'b0, cfg_sign_mult_depth}), .d ({sign_b, sign_a}), .q (sm)
   );
   dsp_ctrl_delay #(.W(2)) u_sign_add (
      .sys_clk (sys_clk), .rst_n (rst_n), .tick (ctrl_tick), .ena (ctrl_ena), .clr (ctrl_clr),
      .depth   (cfg_sign_add_depth), .d ({sign_b, sign_a}), .q (sadd)
   );
   dsp_ctrl_delay #(.W(2)) u_addnsub (
      .sys_clk (sys_clk), .rst_n (rst_n), .tick (ctrl_tick), .ena (ctrl_ena), .clr (ctrl_clr),
      .depth   (cfg_addnsub_depth), .d (addnsub), .q (as_q)
   );
   dsp_ctrl_delay #(.W(2)) u_sload (
      .sys_clk (sys_clk), .rst_n (rst_n), .tick (ctrl_tick), .ena (ctrl_ena), .clr (ctrl_clr),
      .depth   (cfg_sload_depth), .d (accum_sload), .q (sl_q)
   );

   // each operand gets a sign bit on top, so one signed multiply is exact
   always_comb begin
      logic signed [2*SLICE_W+1:0]    t9;
      logic signed [2*OPND18_W+1:0]   t18;
      logic signed [2*OPND36_W+1:0]   t36;
      t9  = '0;
      t18 = '0;
      t36 = '0;
      prod_now = '0;
      case (cfg_size)
         SIZE_9: begin
            for (int k = 0; k < N_SLICE; k++) begin
               t9 = $signed({sm[0] & a_vec[k*SLICE_W+SLICE_W-1], a_vec[k*SLICE_W +: SLICE_W]})
                  * $signed({sm[1] & b_vec[k*SLICE_W+SLICE_W-1], b_vec[k*SLICE_W +: SLICE_W]});
               prod_now[k*PROD9_W +: PROD9_W] = t9[PROD9_W-1:0];
            end
         end
         SIZE_18: begin
            for (int m = 0; m < 4; m++) begin
               t18 = $signed({sm[0] & a_vec[m*OPND18_W+OPND18_W-1], a_vec[m*OPND18_W +: OPND18_W]})
                   * $signed({sm[1] & b_vec[m*OPND18_W+OPND18_W-1], b_vec[m*OPND18_W +: OPND18_W]});
               prod_now[m*PROD18_W +: PROD18_W] = t18[PROD18_W-1:0];
            end
         end
         default: begin
            t36 = $signed({sm[0] & a_vec[OPND36_W-1], a_vec[OPND36_W-1:0]})
                * $signed({sm[1] & b_vec[OPND36_W-1], b_vec[OPND36_W-1:0]});
            prod_now[LANE_W-1:0] = t36[LANE_W-1:0];
         end
      endcase
   end

   assign pipe_ld  = set_tick[cfg_pipe_set] && set_ena[cfg_pipe_set];
   assign pipe_clr = set_clr[cfg_pipe_set];
   assign out_ld   = set_tick[cfg_out_set] && set_ena[cfg_out_set];
   assign out_clr  = set_clr[cfg_out_set];
   assign prod_use = cfg_pipe_reg ? (pipe_clr ? '0 : r.pipe) : prod_now;
   assign out_q    = out_clr ? '0 : r.out;
   assign ps       = sadd[0] | sadd[1];

   // adder stage: widen products, first-level add/sub, sums, accumulators
   always_comb begin
      for (int k = 0; k < N_SLICE; k++) begin
         pe[k] = '0;
         if (cfg_size == SIZE_9) begin
            pe[k] = {{(LANE_W-PROD9_W){ps & prod_use[k*PROD9_W+PROD9_W-1]}},
                     prod_use[k*PROD9_W +: PROD9_W]};
         end else if (k < 4) begin
            pe[k] = {{(LANE_W-PROD18_W){ps & prod_use[k*PROD18_W+PROD18_W-1]}},
                     prod_use[k*PROD18_W +: PROD18_W]};
         end
      end
      for (int k = 0; k < 4; k++) begin
         // small mode: one line per half; middle mode: one line per adder
         if (as_q[(cfg_size == SIZE_9) ? k/2 : k%2]) begin
            s[k] = pe[2*k] + pe[2*k+1];
         end else begin
            s[k] = pe[2*k] - pe[2*k+1];
         end
      end
      u[0] = s[0] + s[1];
      u[1] = s[2] + s[3];
      for (int j = 0; j < 2; j++) begin
         // second multiplier of each half feeds an accumulator
         sum53[j] = {ps & out_q[j*LANE_W+ACC_W-1], out_q[j*LANE_W +: ACC_W]};
         if (as_q[j]) begin
            sum53[j] = sum53[j] + pe[(cfg_size == SIZE_9) ? 4*j+1 : 2*j+1][ACC_W:0];
         end else begin
            sum53[j] = sum53[j] - pe[(cfg_size == SIZE_9) ? 4*j+1 : 2*j+1][ACC_W:0];
         end
         // unsigned wrap shows in the carry, signed in the top two bits
         ovf_now[j] = ps ? (sum53[j][ACC_W] ^ sum53[j][ACC_W-1]) : sum53[j][ACC_W];
         acc_res[j] = sum53[j][ACC_W-1:0];
         if (sl_q[j]) begin
            acc_res[j] = pe[(cfg_size == SIZE_9) ? 4*j+1 : 2*j+1][ACC_W-1:0];
            ovf_now[j] = 1'b0;
         end
      end
   end

   // output selection multiplexer; every path starts at the multipliers
   always_comb begin
      out_now = '0;
      case (eff_mode)
         MODE_SIMPLE: out_now = prod_use;
         MODE_ADD2: begin
            for (int k = 0; k < 4; k++) begin
               if (cfg_size == SIZE_9) begin
                  out_now[k*PROD18_W +: PROD18_W] = s[k][PROD18_W-1:0];
               end else if (k < 2) begin
                  out_now[k*LANE_W +: LANE_W] = s[k];
               end
            end
         end
         MODE_ADD4: begin
            out_now[LANE_W-1:0] = u[0];
            if (cfg_size == SIZE_9) begin
               out_now[VEC_W-1:LANE_W] = u[1];
            end
         end
         MODE_ACCUM: begin
            for (int j = 0; j < 2; j++) begin
               out_now[j*LANE_W +: LANE_W] = {{(LANE_W-ACC_W){ps & acc_res[j][ACC_W-1]}},
                                              acc_res[j]};
            end
         end
         default: out_now = prod_use;
      endcase
   end

   // state update: product register and output register on their own sets
   always_comb begin
      next_r = r;
      if (pipe_clr) begin
         next_r.pipe = '0;
      end else if (pipe_ld) begin
         next_r.pipe = prod_now;
      end
      if (out_clr) begin
         next_r.out = '0;
         next_r.ovf = '0;
      end else if (out_ld) begin
         next_r.out = out_now;
         next_r.ovf = (eff_mode == MODE_ACCUM) ? ovf_now : 2'h0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign result   = use_out ? out_q : out_now;
   assign overflow = out_clr ? 2'h0 : r.ovf;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_unsigned_prod;
      (cfg_size == SIZE_9 && sm == 2'h0)
         |-> prod_now[PROD9_W-1:0] == PROD9_W'(a_vec[SLICE_W-1:0] * b_vec[SLICE_W-1:0]);
   endproperty
   a_unsigned_prod: assert property (p_unsigned_prod) else $error("unsigned product wrong");
   property p_no_chain36;
      (cfg_size == SIZE_36) |-> !shift_a_eff && !shift_b_eff && eff_mode == MODE_SIMPLE;
   endproperty
   a_no_chain36: assert property (p_no_chain36) else $error("large size allowed chain");
   property p_acc_out_reg;
      (eff_mode == MODE_ACCUM) |-> use_out && result == out_q;
   endproperty
   a_acc_out_reg: assert property (p_acc_out_reg) else $error("accumulator not registered");
   // the register itself is checked, since a clear in the next cycle masks the pins
   property p_acc_load;
      (eff_mode == MODE_ACCUM && out_ld && !out_clr && sl_q[0])
         |=> r.out[ACC_W-1:0] == $past(pe[1][ACC_W-1:0]) && !r.ovf[0];
   endproperty
   a_acc_load: assert property (p_acc_load) else $error("sync load not taken");
   property p_pipe_stage;
      (pipe_ld && !pipe_clr) ##1 (cfg_pipe_reg && !pipe_clr && $stable(cfg_pipe_reg))
         |-> prod_use == $past(prod_now);
   endproperty
   a_pipe_stage: assert property (p_pipe_stage) else $error("product register skipped");
   property p_out_clear;
      (use_out && out_clr) |-> result == '0 && overflow == 2'h0;
   endproperty
   a_out_clear: assert property (p_out_clear) else $error("output clear not immediate");
   c_overflow: cover property (eff_mode == MODE_ACCUM && overflow != 2'h0);
   c_chain:    cover property (shift_a_eff && out_ld ##1 out_ld);
   c_add4:     cover property (eff_mode == MODE_ADD4 && cfg_size == SIZE_18 && use_out);
endmodule
`default_nettype wire

// file: common/dsp_pkg.sv
// shared constants and types for the multiply and add datapath
package dsp_pkg;
   localparam int SLICE_W  = 9;    // operand width of one small multiplier
   localparam int N_SLICE  = 8;    // small multipliers per block
   localparam int PROD9_W  = 18;   // full product of the small size
   localparam int PROD18_W = 36;   // full product of the middle size
   localparam int OPND18_W = 18;
   localparam int OPND36_W = 36;
   localparam int LANE_W   = 72;   // full product of the large size
   localparam int VEC_W    = 144;  // packed product and result vector
   localparam int ACC_W    = 52;   // 36-bit product plus 16 growth bits
   localparam int CASC_W   = 18;
   localparam int SET_W    = 2;    // selects one of four control sets
   localparam int N_SET    = 4;
   localparam int MAX_CHAIN = 224; // longest input chain across blocks
   localparam logic [1:0] DEPTH_NONE = 2'h0;
   localparam logic [1:0] DEPTH_ONE  = 2'h1;
   localparam logic [1:0] DEPTH_TWO  = 2'h2;
   typedef enum logic [1:0] {MODE_SIMPLE, MODE_ACCUM, MODE_ADD2, MODE_ADD4} mode_t;
   typedef enum logic [1:0] {SIZE_9, SIZE_18, SIZE_36} size_t;
endpackage

// file: logic/dsp_operand_slice.sv
// one optional operand input register, loaded in parallel or from the chain
`timescale 1ns/1ps
`default_nettype none
module dsp_operand_slice
   import dsp_pkg::*;
(
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   // selected control set
   input  wire logic               tick,
   input  wire logic               ena,
   input  wire logic               clr,
   // configuration
   input  wire logic               use_reg,
   input  wire logic               shift_sel,
   // data
   input  wire logic [SLICE_W-1:0] par_in,
   input  wire logic [SLICE_W-1:0] shift_in,
   output logic      [SLICE_W-1:0] q,
   output logic      [SLICE_W-1:0] reg_q
);
   typedef struct packed {
      logic [SLICE_W-1:0] data;
   } slice_state_t;

   slice_state_t r;
   slice_state_t next_r;

   // clear beats enable; chain source or parallel pin per configuration
   always_comb begin
      next_r = r;
      if (clr) begin
         next_r.data = '0;
      end else if (tick && ena) begin
         next_r.data = shift_sel ? shift_in : par_in;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // clear masks the stored value at once, so it is visible before the edge
   assign reg_q = clr ? '0 : r.data;
   assign q     = use_reg ? reg_q : par_in;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_slice_clear;
      clr |-> (reg_q == '0) ##1 (r.data == '0);
   endproperty
   a_slice_clear: assert property (p_slice_clear) else $error("slice clear not zero");

   property p_slice_load;
      (tick && ena && !clr && shift_sel) |=> (r.data == $past(shift_in));
   endproperty
   a_slice_load: assert property (p_slice_load) else $error("chain load lost");
endmodule
`default_nettype wire

// file: logic/dsp_ctrl_delay.sv
// zero, one or two register stages for dynamic control lines
`timescale 1ns/1ps
`default_nettype none
module dsp_ctrl_delay
   import dsp_pkg::*;
#(
   parameter int W = 2
)(
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   // selected control set
   input  wire logic         tick,
   input  wire logic         ena,
   input  wire logic         clr,
   // configuration and data
   input  wire logic [1:0]   depth,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } delay_state_t;

   delay_state_t r;
   delay_state_t next_r;

   // both stages advance together on the selected enable
   always_comb begin
      next_r = r;
      if (clr) begin
         next_r = '0;
      end else if (tick && ena) begin
         next_r.s1 = d;
         next_r.s2 = r.s1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // pick the tap that matches the data path latency
   always_comb begin
      case (depth)
         DEPTH_NONE: q = d;
         DEPTH_ONE:  q = clr ? '0 : r.s1;
         default:    q = clr ? '0 : r.s2;
      endcase
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_two_stage;
      (depth == DEPTH_TWO && tick && ena && !clr) ##1 (tick && ena && !clr && depth == DEPTH_TWO)
         |=> (r.s2 == $past(d, 2));
   endproperty
   a_two_stage: assert property (p_two_stage) else $error("two stage delay wrong");
endmodule
`default_nettype wire

// file: test/dsp_fabric_model.sv
// fabric-side model that feeds the operand chain of the block
`timescale 1ns/1ps
`default_nettype none
module dsp_fabric_model (
   // clock and push request
   input  wire logic        sys_clk,
   input  wire logic        push,
   input  wire logic [8:0]  val,
   // chain lines into the block
   output logic      [17:0] chain_a,
   output logic      [17:0] chain_b
);
   // one value per push, launched after the edge so the block sees it a full cycle
   always @(posedge sys_clk) begin
      chain_a <= push ? {9'h000, val} : 18'h00000;
      chain_b <= push ? {9'h000, ~val} : 18'h00000;
   end
endmodule
`default_nettype wire

// file: test/tb_dsp_multiply_accumulate.sv
// self-checking bench for the multiply and add datapath
`timescale 1ns/1ps
`default_nettype none
module tb_dsp_multiply_accumulate;
   import dsp_pkg::*;
   logic         sys_clk = 1'b0;
   logic         rst_n = 1'b0;
   logic [3:0]   tick = 4'hf, ena = 4'hf, clr = 4'h0;
   size_t        sz = SIZE_18;
   mode_t        md = MODE_SIMPLE;
   logic [7:0]   ireg = 8'h00;
   logic [15:0]  iset = 16'h0000;
   logic [1:0]   cset = 2'h0, dep = 2'h0, ans = 2'h3, sld = 2'h0, ov;
   logic         shf = 1'b0, sa = 1'b0, sb = 1'b0, push = 1'b0, preg = 1'b0, oreg = 1'b0;
   logic [71:0]  da = 72'h0, db = 72'h0;
   logic [8:0]   pval = 9'h000;
   logic [17:0]  cia, cib, coa, cob;
   logic [143:0] res;
   int           mismatches = 0, cmp_count = 0;
   // free-running clock, 10 ns
   always #5 sys_clk = ~sys_clk;
   dsp_multiply_accumulate dsp_multiply_accumulate_i (
      .sys_clk(sys_clk), .rst_n(rst_n), .set_tick(tick), .set_ena(ena), .set_clr(clr),
      .cfg_size(sz), .cfg_mode(md), .cfg_in_reg_a(ireg), .cfg_in_reg_b(ireg),
      .cfg_in_set_a(iset), .cfg_in_set_b(iset), .cfg_shift_a(shf), .cfg_shift_b(shf),
      .cfg_pipe_reg(preg), .cfg_pipe_set(cset), .cfg_out_reg(oreg), .cfg_out_set(cset),
      .cfg_ctrl_set(cset), .cfg_sign_mult_depth(dep[0]), .cfg_sign_add_depth(dep),
      .cfg_addnsub_depth(dep), .cfg_sload_depth(dep), .data_a(da), .data_b(db),
      .cascade_in_a(cia), .cascade_in_b(cib), .sign_a(sa), .sign_b(sb), .addnsub(ans),
      .accum_sload(sld), .result(res), .overflow(ov), .cascade_out_a(coa),
      .cascade_out_b(cob));
   dsp_fabric_model dsp_fabric_model_i (
      .sys_clk(sys_clk), .push(push), .val(pval), .chain_a(cia), .chain_b(cib));
   task automatic chk(input string nm, input logic [71:0] ex, input logic [71:0] got);
      cmp_count++;
      if (got !== ex) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // all four sign settings on one middle-size product: -1 or 262143 times 2
   task automatic t_sign;
      sz = SIZE_18;
      da[17:0] = 18'h3ffff;
      db[17:0] = 18'h00002;
      for (int k = 0; k < 4; k++) begin
         @(negedge sys_clk);
         {sa, sb} = k[1:0];
         #1 chk("product", sa ? 72'hffffffffe : 72'h7fffe, res[35:0]);
      end
      $display("done sign");
   endtask
   // large size through the product register: one load late, then the signed product
   task automatic t_big;
      @(negedge sys_clk);
      {sa, sb, da, db} = {2'h0, 144'h0};
      sz = SIZE_36;
      preg = 1'b1;
      da[35:0] = 36'hfffffffff;
      db[35:0] = 36'h000000003;
      @(negedge sys_clk);
      chk("big", 72'h2ffffffffd, res[71:0]);
      sa = 1'b1;
      #1 chk("big_hold", 72'h2ffffffffd, res[71:0]);
      @(negedge sys_clk);
      chk("big_sign", 72'hfffffffffffffffffd, res[71:0]);
      preg = 1'b0;
      $display("done big");
   endtask
   // pair difference then pair sum in small size, then the four-product sum in middle size
   task automatic t_add;
      @(negedge sys_clk);
      {sa, sb, da, db} = {2'h0, 144'h0};
      sz = SIZE_9;
      md = MODE_ADD2;
      da[17:0] = {9'h002, 9'h003};
      db[17:0] = {9'h005, 9'h004};
      for (int k = 0; k < 2; k++) begin
         ans = {1'b1, k[0]};
         #1 chk("pair", k ? 72'h16 : 72'h2, res[35:0]);
         @(negedge sys_clk);
      end
      sz = SIZE_18;
      md = MODE_ADD4;
      da = {18'h4, 18'h3, 18'h2, 18'h1};
      db = {18'h1, 18'h1, 18'h1, 18'h1};
      #1 chk("sum4", 72'ha, res[71:0]);
      // two control stages: the subtract on adder one shows after the second load
      @(negedge sys_clk);
      {dep, ans} = 4'h9;
      #1 chk("depth_hold", 72'ha, res[71:0]);
      @(negedge sys_clk);
      #1 chk("depth_one", 72'ha, res[71:0]);
      @(negedge sys_clk);
      #1 chk("depth_two", 72'h2, res[71:0]);
      {dep, ans} = 4'h3;
      $display("done add");
   endtask
   // load, add, subtract down through zero, reload, then clear
   task automatic t_accum;
      @(negedge sys_clk);
      md = MODE_ACCUM;
      {da, db} = {72'h0, 72'h0};
      da[35:18] = 18'h00005;
      db[35:18] = 18'h00007;
      {sld, ans} = 4'h7;
      @(negedge sys_clk);
      chk("load", 72'h23, res[51:0]);
      sld = 2'h0;
      @(negedge sys_clk);
      chk("acc", 72'h46, res[51:0]);
      ans = 2'h2;
      repeat (3) @(negedge sys_clk);
      chk("under", 72'hfffffffffffdd, res[51:0]);
      chk("ovf", 72'h1, ov);
      sld = 2'h1;
      @(negedge sys_clk);
      chk("ovf_drop", 72'h0, ov[0]);
      clr[0] = 1'b1;
      #1 chk("clear", 72'h0, res[71:0]);
      @(negedge sys_clk);
      {clr, sld} = 6'h0;
      $display("done accum");
   endtask
   // one value pushed into the chain reaches the chain output after eight loads
   task automatic t_shift;
      @(negedge sys_clk);
      sz = SIZE_9;
      md = MODE_SIMPLE;
      {shf, ireg, pval, push} = {1'b1, 8'hff, 9'h1a5, 1'b1};
      @(negedge sys_clk);
      push = 1'b0;
      repeat (7) @(negedge sys_clk);
      chk("chain7", 72'h0, coa[8:0]);
      chk("chain7_b", 72'h0, cob[8:0]);
      @(negedge sys_clk);
      chk("chain8", 72'h1a5, coa[8:0]);
      chk("chain8_b", 72'h05a, cob[8:0]);
      $display("done shift");
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // main sequence after ten cycles of reset
   initial begin
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      t_sign;
      t_big;
      t_add;
      t_accum;
      t_shift;
      complete_run;
   end
   // the tests need well under a microsecond; a hang is cut short here
   initial begin
      #20000;
      mismatches++;
      complete_run;
   end
endmodule
`default_nettype wire
